// *** core/ampctl_top.sv ***
// Amplifier control register bank with AXI4-Lite slave and mode decode
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps

module ampctl_top
(
    // Clock and reset
    input  wire logic                      i_clock,
    input  wire logic                      i_rst,
    // AXI4-Lite write address and data
    input  wire logic [ampctl_pkg::ADDR_W-1:0] i_awaddr,
    input  wire logic                      i_awvalid,
    output logic                           o_awready,
    input  wire logic [31:0]               i_wdata,
    input  wire logic [3:0]                i_wstrb,
    input  wire logic                      i_wvalid,
    output logic                           o_wready,
    output logic [1:0]                     o_bresp,
    output logic                           o_bvalid,
    input  wire logic                      i_bready,
    // AXI4-Lite read
    input  wire logic [ampctl_pkg::ADDR_W-1:0] i_araddr,
    input  wire logic                      i_arvalid,
    output logic                           o_arready,
    output logic [31:0]                    o_rdata,
    output logic [1:0]                     o_rresp,
    output logic                           o_rvalid,
    input  wire logic                      i_rready,
    // Override source and converter routing
    input  wire logic                      i_override,
    input  wire logic                      i_conv_feed,
    input  wire logic [1:0]                i_conv_pos_pin,
    input  wire logic [2:0]                i_conv_neg_pin,
    // Analog controls
    output logic                           o_amp_enable,
    output logic                           o_charge_pump_on,
    output ampctl_pkg::ampctl_mode_t       o_mode,
    output logic [2:0]                     o_gain_sel,
    output logic                           o_ladder_enable,
    output logic [2:0]                     o_neg_pin_sel,
    output logic [2:0]                     o_inv_source_sel,
    output logic [2:0]                     o_noninv_source_sel,
    output logic [1:0]                     o_feedback_mode_sel,
    output logic [1:0]                     o_pos_pin_sel,
    output logic                           o_out_pin_owned
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] ctrl_main_q;
    logic [7:0] gain_neg_q;
    logic [7:0] chan_sel_q;
    logic [7:0] fb_pos_q;
    logic [7:0] ovr_ctrl_q;

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    logic [ampctl_pkg::ADDR_W-1:0] aw_addr_q;
    logic                          aw_have_q;
    logic [31:0]                   w_data_q;
    logic [3:0]                    w_strb_q;
    logic                          w_have_q;
    logic                          wr_go;
    logic [11:0]                   wr_idx;
    logic                          wr_hit;

    assign wr_go  = aw_have_q && w_have_q && !o_bvalid;
    assign wr_idx = aw_addr_q[ampctl_pkg::ADDR_W-1:2];
    assign wr_hit = (aw_addr_q[1:0] == 2'h0)
                 && (wr_idx >= ampctl_pkg::IDX_CONTROL_MAIN)
                 && (wr_idx <= ampctl_pkg::IDX_OVERRIDE_CTRL);

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
            o_awready <= 1'b0;
        end
        else if (o_awready && i_awvalid)
        begin
            aw_have_q <= 1'b1;
            aw_addr_q <= i_awaddr;
            o_awready <= 1'b0;
        end
        else if (wr_go)
        begin
            aw_have_q <= 1'b0;
        end
        else
        begin
            o_awready <= !aw_have_q && !o_bvalid;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            w_have_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
            o_wready <= 1'b0;
        end
        else if (o_wready && i_wvalid)
        begin
            w_have_q <= 1'b1;
            w_data_q <= i_wdata;
            w_strb_q <= i_wstrb;
            o_wready <= 1'b0;
        end
        else if (wr_go)
        begin
            w_have_q <= 1'b0;
        end
        else
        begin
            o_wready <= !w_have_q && !o_bvalid;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_bvalid <= 1'b0;
            o_bresp  <= ampctl_pkg::RESP_OKAY;
        end
        else if (wr_go)
        begin
            o_bvalid <= 1'b1;
            o_bresp  <= wr_hit ? ampctl_pkg::RESP_OKAY : ampctl_pkg::RESP_SLVERR;
        end
        else if (i_bready)
        begin
            o_bvalid <= 1'b0;
        end
    end

    // Register store; only byte lane 0 carries data, reserved bits of the main register stay 0
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctrl_main_q <= ampctl_pkg::RST_CONTROL_MAIN;
            gain_neg_q  <= ampctl_pkg::RST_OTHER;
            chan_sel_q  <= ampctl_pkg::RST_OTHER;
            fb_pos_q    <= ampctl_pkg::RST_OTHER;
            ovr_ctrl_q  <= ampctl_pkg::RST_OVERRIDE_CTRL;
        end
        else if (wr_go && wr_hit && w_strb_q[0])
        begin
            unique case (wr_idx)
                ampctl_pkg::IDX_CONTROL_MAIN:
                    ctrl_main_q <= w_data_q[7:0] & ampctl_pkg::MASK_CONTROL_MAIN;
                ampctl_pkg::IDX_GAIN_NEG_PIN:   gain_neg_q <= w_data_q[7:0];
                ampctl_pkg::IDX_CHANNEL_SELECT: chan_sel_q <= w_data_q[7:0];
                ampctl_pkg::IDX_FEEDBACK_POS:   fb_pos_q   <= w_data_q[7:0];
                default:                        ovr_ctrl_q <= w_data_q[7:0];
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    logic [11:0] rd_idx;
    logic [7:0]  rd_byte;
    logic        rd_hit;

    assign rd_idx = i_araddr[ampctl_pkg::ADDR_W-1:2];
    assign rd_hit = (i_araddr[1:0] == 2'h0)
                 && (rd_idx >= ampctl_pkg::IDX_CONTROL_MAIN)
                 && (rd_idx <= ampctl_pkg::IDX_OVERRIDE_CTRL);

    always_comb
    begin
        unique case (rd_idx)
            ampctl_pkg::IDX_CONTROL_MAIN:   rd_byte = ctrl_main_q;
            ampctl_pkg::IDX_GAIN_NEG_PIN:   rd_byte = gain_neg_q;
            ampctl_pkg::IDX_CHANNEL_SELECT: rd_byte = chan_sel_q;
            ampctl_pkg::IDX_FEEDBACK_POS:   rd_byte = fb_pos_q;
            ampctl_pkg::IDX_OVERRIDE_CTRL:  rd_byte = ovr_ctrl_q;
            default:                        rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= '0;
            o_rresp   <= ampctl_pkg::RESP_OKAY;
        end
        else if (o_arready && i_arvalid)
        begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rdata   <= {24'h000000, rd_hit ? rd_byte : 8'h00};
            o_rresp   <= rd_hit ? ampctl_pkg::RESP_OKAY : ampctl_pkg::RESP_SLVERR;
        end
        else if (o_rvalid)
        begin
            if (i_rready)
            begin
                o_rvalid <= 1'b0;
            end
        end
        else
        begin
            o_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Override synchroniser and mode decode
    // ------------------------------------------------------------
    logic       ovr_meta_q;
    logic       ovr_sync_q;
    logic       ovr_level;
    logic [2:0] ovr_cfg;
    ampctl_pkg::ampctl_mode_t mode_d;

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            ovr_meta_q <= 1'b0;
            ovr_sync_q <= 1'b0;
        end
        else
        begin
            ovr_meta_q <= i_override;
            ovr_sync_q <= ovr_meta_q;
        end
    end

    assign ovr_level = ovr_sync_q ^ ovr_ctrl_q[ampctl_pkg::BIT_OVR_POLARITY];
    assign ovr_cfg   = ovr_level ? ovr_ctrl_q[ampctl_pkg::LSB_OVR_HIGH +: 3]
                                 : ovr_ctrl_q[ampctl_pkg::LSB_OVR_LOW +: 3];

    always_comb
    begin
        mode_d = ampctl_pkg::AMPCTL_MODE_USER;
        if (ovr_ctrl_q[ampctl_pkg::BIT_OVR_ENABLE])
        begin
            // Reserved override codes fall back to user feedback
            unique case (ovr_cfg)
                ampctl_pkg::OVR_UNITY: mode_d = ampctl_pkg::AMPCTL_MODE_UNITY;
                ampctl_pkg::OVR_RAIL:
                    mode_d = ovr_level ? ampctl_pkg::AMPCTL_MODE_RAIL_HI
                                       : ampctl_pkg::AMPCTL_MODE_RAIL_LO;
                default:               mode_d = ampctl_pkg::AMPCTL_MODE_USER;
            endcase
        end
        else
        begin
            unique case (ctrl_main_q[ampctl_pkg::LSB_SOFT_OUT +: 2])
                ampctl_pkg::SOC_RAIL_LO: mode_d = ampctl_pkg::AMPCTL_MODE_RAIL_LO;
                ampctl_pkg::SOC_RAIL_HI: mode_d = ampctl_pkg::AMPCTL_MODE_RAIL_HI;
                default:
                    mode_d = ctrl_main_q[ampctl_pkg::BIT_UNITY]
                           ? ampctl_pkg::AMPCTL_MODE_UNITY
                           : ampctl_pkg::AMPCTL_MODE_USER;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Source selections with reserved-code cleanup
    // ------------------------------------------------------------
    logic [2:0] neg_raw;
    logic [2:0] inv_raw;
    logic [2:0] non_raw;
    logic [1:0] fb_raw;
    logic [2:0] neg_d;
    logic [2:0] inv_d;
    logic [2:0] non_d;
    logic [1:0] fb_d;
    logic [1:0] pos_d;

    assign neg_raw = i_conv_feed ? i_conv_neg_pin
                                 : gain_neg_q[ampctl_pkg::LSB_NEG_PIN +: 3];
    assign pos_d   = i_conv_feed ? i_conv_pos_pin
                                 : fb_pos_q[ampctl_pkg::LSB_POS_PIN +: 2];
    assign inv_raw = chan_sel_q[ampctl_pkg::LSB_INV_SRC +: 3];
    assign non_raw = chan_sel_q[ampctl_pkg::LSB_NONINV_SRC +: 3];
    assign fb_raw  = fb_pos_q[ampctl_pkg::LSB_FEEDBACK +: 2];

    // Reserved codes collapse to the zero setting so the analog side never sees them
    assign neg_d = (neg_raw <= ampctl_pkg::NEG_PIN_MAX || neg_raw == ampctl_pkg::NEG_GROUND)
                 ? neg_raw : 3'h0;
    assign inv_d = (inv_raw == ampctl_pkg::SRC_HALF || inv_raw > ampctl_pkg::SRC_CONV2)
                 ? ampctl_pkg::SRC_NONE : inv_raw;
    assign non_d = (non_raw > ampctl_pkg::SRC_CONV2) ? ampctl_pkg::SRC_NONE : non_raw;
    assign fb_d  = (fb_raw == ampctl_pkg::FB_NONE || fb_raw == ampctl_pkg::FB_SUPPLY
                 || fb_raw == ampctl_pkg::FB_OUT_PIN) ? fb_raw : ampctl_pkg::FB_NONE;

    // ------------------------------------------------------------
    // Registered analog controls
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_amp_enable        <= 1'b0;
            o_charge_pump_on    <= 1'b0;
            o_mode              <= ampctl_pkg::AMPCTL_MODE_USER;
            o_gain_sel          <= 3'h0;
            o_ladder_enable     <= 1'b0;
            o_neg_pin_sel       <= 3'h0;
            o_inv_source_sel    <= 3'h0;
            o_noninv_source_sel <= 3'h0;
            o_feedback_mode_sel <= 2'h0;
            o_pos_pin_sel       <= 2'h0;
            o_out_pin_owned     <= 1'b0;
        end
        else
        begin
            o_amp_enable        <= ctrl_main_q[ampctl_pkg::BIT_ENABLE];
            o_charge_pump_on    <= ctrl_main_q[ampctl_pkg::BIT_CHARGE_PUMP];
            o_mode              <= mode_d;
            o_gain_sel          <= gain_neg_q[ampctl_pkg::LSB_GAIN +: 3];
            o_ladder_enable     <= gain_neg_q[ampctl_pkg::BIT_LADDER];
            o_neg_pin_sel       <= neg_d;
            o_inv_source_sel    <= inv_d;
            o_noninv_source_sel <= non_d;
            o_feedback_mode_sel <= fb_d;
            o_pos_pin_sel       <= pos_d;
            // Enabled amplifier or converter route keeps the output pin from general I/O
            o_out_pin_owned     <= ctrl_main_q[ampctl_pkg::BIT_ENABLE] || i_conv_feed;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    enable_follow_a: assert property
        (o_amp_enable == $past(ctrl_main_q[7]))
        else $error("enable output does not follow register");
    pump_follow_a: assert property
        (o_charge_pump_on == $past(ctrl_main_q[5]))
        else $error("charge pump output does not follow register");
    soft_rail_a: assert property
        (!ovr_ctrl_q[7] && ctrl_main_q[1:0] == 2'h2 ##1 1'b1
         |-> o_mode == ampctl_pkg::AMPCTL_MODE_RAIL_HI)
        else $error("software high rail not applied");
    unity_soft_a: assert property
        (!ovr_ctrl_q[7] && ctrl_main_q[1:0] == 2'h0 && ctrl_main_q[3]
         |=> o_mode == ampctl_pkg::AMPCTL_MODE_UNITY)
        else $error("unity mode not applied");
    ovr_rail_lo_a: assert property
        (ovr_ctrl_q == 8'h87 && ovr_sync_q == 1'b0
         |=> o_mode == ampctl_pkg::AMPCTL_MODE_RAIL_LO)
        else $error("low override rail not applied");
    ovr_polarity_a: assert property
        (ovr_ctrl_q == 8'hf8 && ovr_sync_q == 1'b0
         |=> o_mode == ampctl_pkg::AMPCTL_MODE_RAIL_HI)
        else $error("inverted override did not pick high config");
    ovr_sync_a: assert property
        ($rose(i_override) && ovr_ctrl_q == 8'hc0 ##1 ovr_ctrl_q == 8'hc0 [*3]
         |-> o_mode == ampctl_pkg::AMPCTL_MODE_UNITY)
        else $error("override not seen after sync delay");
    inv_reserved_a: assert property
        (o_inv_source_sel != 3'h3 && o_inv_source_sel < 3'h6)
        else $error("reserved inverting source reached output");
    conv_pin_a: assert property
        (i_conv_feed |=> o_pos_pin_sel == $past(i_conv_pos_pin))
        else $error("converter pin select not applied");
    pin_owned_a: assert property
        (i_conv_feed |=> o_out_pin_owned)
        else $error("output pin released during converter route");
    write_resp_a: assert property
        (wr_go |=> o_bvalid)
        else $error("write response missing");

    cover_write_c:  cover property (o_bvalid && i_bready && o_bresp == ampctl_pkg::RESP_OKAY);
    cover_read_c:   cover property (o_rvalid && i_rready);
    cover_ovr_c:    cover property (ovr_ctrl_q[7] && o_mode == ampctl_pkg::AMPCTL_MODE_RAIL_HI);
    cover_conv_c:   cover property (i_conv_feed && o_amp_enable);

endmodule

// *** core/ampctl_pkg.sv ***
// Package: register map, field positions and decode codes for the amplifier control bank
package ampctl_pkg;

    // ------------------------------------------------------------
    // Register word indices
    // ------------------------------------------------------------
    // Printed offsets are not all multiples of four: they are indices, byte address = 4 * index
    localparam logic [11:0] IDX_CONTROL_MAIN   = 12'h90c;
    localparam logic [11:0] IDX_GAIN_NEG_PIN   = 12'h90d;
    localparam logic [11:0] IDX_CHANNEL_SELECT = 12'h90e;
    localparam logic [11:0] IDX_FEEDBACK_POS   = 12'h90f;
    localparam logic [11:0] IDX_OVERRIDE_CTRL  = 12'h910;
    localparam int          ADDR_W             = 14;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CONTROL_MAIN  = 8'h00;
    localparam logic [7:0] RST_OTHER         = 8'h00;
    localparam logic [7:0] RST_OVERRIDE_CTRL = 8'h00;
    localparam logic [7:0] MASK_CONTROL_MAIN = 8'hab;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_ENABLE        = 7;
    localparam int BIT_CHARGE_PUMP   = 5;
    localparam int BIT_UNITY         = 3;
    localparam int LSB_SOFT_OUT      = 0;
    localparam int LSB_GAIN          = 4;
    localparam int BIT_LADDER        = 3;
    localparam int LSB_NEG_PIN       = 0;
    localparam int LSB_INV_SRC       = 4;
    localparam int LSB_NONINV_SRC    = 0;
    localparam int LSB_FEEDBACK      = 6;
    localparam int LSB_POS_PIN       = 0;
    localparam int BIT_OVR_ENABLE    = 7;
    localparam int LSB_OVR_HIGH      = 4;
    localparam int BIT_OVR_POLARITY  = 3;
    localparam int LSB_OVR_LOW       = 0;

    // ------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------
    localparam logic [1:0] SOC_NORMAL   = 2'h0;
    localparam logic [1:0] SOC_RAIL_LO  = 2'h1;
    localparam logic [1:0] SOC_RAIL_HI  = 2'h2;
    localparam logic [2:0] OVR_USER     = 3'h0;
    localparam logic [2:0] OVR_UNITY    = 3'h4;
    localparam logic [2:0] OVR_RAIL     = 3'h7;
    localparam logic [2:0] NEG_PIN_MAX  = 3'h3;
    localparam logic [2:0] NEG_GROUND   = 3'h7;
    localparam logic [2:0] SRC_NONE     = 3'h0;
    localparam logic [2:0] SRC_LADDER   = 3'h1;
    localparam logic [2:0] SRC_PIN      = 3'h2;
    localparam logic [2:0] SRC_HALF     = 3'h3;
    localparam logic [2:0] SRC_CONV1    = 3'h4;
    localparam logic [2:0] SRC_CONV2    = 3'h5;
    localparam logic [1:0] FB_NONE      = 2'h0;
    localparam logic [1:0] FB_SUPPLY    = 2'h1;
    localparam logic [1:0] FB_OUT_PIN   = 2'h2;

    // Decoded operating mode driven to the analog block
    typedef enum logic [1:0]
    {
        AMPCTL_MODE_USER     = 2'h0,
        AMPCTL_MODE_UNITY    = 2'h1,
        AMPCTL_MODE_RAIL_LO  = 2'h2,
        AMPCTL_MODE_RAIL_HI  = 2'h3
    } ampctl_mode_t;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** dv/ampctl_amp_model.sv ***
// Behavioural model of the analog amplifier output stage
`timescale 1ns/1ps
module ampctl_amp_model
(
    // Controls from the register bank
    input  wire logic                     i_amp_enable,
    input  wire ampctl_pkg::ampctl_mode_t i_mode,
    // Stage state: 0 off, 1 linear, 2 low rail, 3 high rail
    output logic [1:0]                    o_drive
);
    // Power gate wins over mode, so a rail code never drives a dead amplifier
    always_comb
    begin
        if (!i_amp_enable)
            o_drive = 2'h0;
        else if (i_mode == ampctl_pkg::AMPCTL_MODE_RAIL_LO)
            o_drive = 2'h2;
        else if (i_mode == ampctl_pkg::AMPCTL_MODE_RAIL_HI)
            o_drive = 2'h3;
        else
            o_drive = 2'h1;
    end
endmodule

// *** dv/opamp_control_registers_test.sv ***
// Self-checking bench for the amplifier control register bank
`timescale 1ns/1ps
module opamp_control_registers_test;
    logic        clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, brdy = 1'b0;
    logic        arv = 1'b0, rrdy = 1'b0, ovr = 1'b0, feed = 1'b0;
    logic [13:0] awa = 14'h0, ara = 14'h0;
    logic [31:0] wd = 32'h0, rdat, rd;
    logic [1:0]  cpos = 2'h0, bresp, rresp, resp, fb, pos, drv;
    logic [2:0]  cneg = 3'h0, gain, neg, inv, ninv;
    logic        awr, wr_rdy, bv, arr, rv, en, cp, lad, own;
    ampctl_pkg::ampctl_mode_t mode;
    int          mismatches = 0, checks = 0;
    localparam logic [13:0] MAIN = {ampctl_pkg::IDX_CONTROL_MAIN, 2'b00};
    localparam logic [13:0] GAIN = {ampctl_pkg::IDX_GAIN_NEG_PIN, 2'b00};
    localparam logic [13:0] CHAN = {ampctl_pkg::IDX_CHANNEL_SELECT, 2'b00};
    localparam logic [13:0] FBP  = {ampctl_pkg::IDX_FEEDBACK_POS, 2'b00};
    localparam logic [13:0] OVRC = {ampctl_pkg::IDX_OVERRIDE_CTRL, 2'b00};

    always #20 clk = ~clk;

    ampctl_top ampctl_top_inst
    (
        .i_clock(clk), .i_rst(rst), .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr),
        .i_wdata(wd), .i_wstrb(4'h1), .i_wvalid(wv), .o_wready(wr_rdy), .o_bresp(bresp),
        .o_bvalid(bv), .i_bready(brdy), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr),
        .o_rdata(rdat), .o_rresp(rresp), .o_rvalid(rv), .i_rready(rrdy), .i_override(ovr),
        .i_conv_feed(feed), .i_conv_pos_pin(cpos), .i_conv_neg_pin(cneg), .o_amp_enable(en),
        .o_charge_pump_on(cp), .o_mode(mode), .o_gain_sel(gain), .o_ladder_enable(lad),
        .o_neg_pin_sel(neg), .o_inv_source_sel(inv), .o_noninv_source_sel(ninv),
        .o_feedback_mode_sel(fb), .o_pos_pin_sel(pos), .o_out_pin_owned(own)
    );
    ampctl_amp_model ampctl_amp_model_inst (.i_amp_enable(en), .i_mode(mode), .o_drive(drv));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic settle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    // Bus master: holds each channel until its own ready, waits for the answer
    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        awa <= a;
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        for (n = 0; n < 50 && !(bv && brdy); n++)
        begin
            @(posedge clk);
            if (awr)
                awv <= 1'b0;
            if (wr_rdy)
                wv <= 1'b0;
        end
        resp = bresp;
        brdy <= 1'b0;
        if (n == 50)
        begin
            mismatches++;
            give_verdict;
        end
        settle(1);
    endtask

    task automatic rdr(input logic [13:0] a);
        int n;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rrdy <= 1'b1;
        for (n = 0; n < 50 && !(rv && rrdy); n++)
        begin
            @(posedge clk);
            if (arr)
                arv <= 1'b0;
        end
        rd = rdat;
        resp = rresp;
        rrdy <= 1'b0;
        if (n == 50)
        begin
            mismatches++;
            give_verdict;
        end
    endtask

    task automatic wcheck(input logic [13:0] a, input logic [7:0] d, input logic [31:0] e);
        wr(a, d);
        chk({en, cp, mode, gain, lad, neg, inv, ninv, fb, pos, own}, e);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        settle(3);
        for (int i = 0; i < 5; i++)
        begin
            rdr(MAIN + 14'(4 * i));
            chk(rd, 32'h0);
        end
        wr(MAIN, 8'hff);
        rdr(MAIN);
        chk(rd, 32'(ampctl_pkg::MASK_CONTROL_MAIN));
        chk({en, cp, mode, drv}, 32'h35);
        wcheck(MAIN, 8'h80, 32'h200001);
        wcheck(MAIN, 8'ha1, 32'h380001);
        wcheck(MAIN, 8'h02, 32'h0c0000);
        wcheck(GAIN, 8'h7f, 32'h0ff800);
        wcheck(GAIN, 8'h05, 32'h0c0000);
        wcheck(CHAN, 8'h53, 32'h0c0560);
        wcheck(CHAN, 8'h36, 32'h0c0000);
        wcheck(FBP, 8'h83, 32'h0c0016);
        wcheck(FBP, 8'hc1, 32'h0c0002);
        $display("test fields done");
        wr(MAIN, 8'h80);
        wr(OVRC, 8'hc0);
        @(posedge clk);
        ovr <= 1'b1;
        settle(2);
        chk(mode, ampctl_pkg::AMPCTL_MODE_USER);
        settle(4);
        chk({mode, drv}, 4'h5);
        @(posedge clk);
        ovr <= 1'b0;
        settle(5);
        chk(mode, ampctl_pkg::AMPCTL_MODE_USER);
        wr(OVRC, 8'hf8);
        settle(4);
        chk(mode, ampctl_pkg::AMPCTL_MODE_RAIL_HI);
        wr(OVRC, 8'h87);
        settle(4);
        chk(mode, ampctl_pkg::AMPCTL_MODE_RAIL_LO);
        wr(OVRC, 8'h77);
        chk(mode, ampctl_pkg::AMPCTL_MODE_USER);
        $display("test override done");
        wr(MAIN, 8'h00);
        wr(GAIN, 8'h02);
        @(posedge clk);
        feed <= 1'b1;
        cpos <= 2'h3;
        cneg <= 3'h1;
        settle(3);
        chk({pos, neg, own}, 32'h33);
        @(posedge clk);
        feed <= 1'b0;
        settle(3);
        chk({pos, neg, own}, 32'h14);
        wr(14'h2444, 8'h5a);
        chk(resp, ampctl_pkg::RESP_SLVERR);
        rdr(14'h2444);
        chk(rd, 32'h0);
        chk(resp, ampctl_pkg::RESP_SLVERR);
        $display("test routing done");
        give_verdict;
    end
endmodule
